/* File: inc/gdc_pkg.sv */
package gdc_pkg;

    // ****************************************
    // Command bytes seen with attention true
    // ****************************************
    localparam logic [7:0] GDC_CMD_GTL = 8'h01;
    localparam logic [7:0] GDC_CMD_SDC = 8'h04;
    localparam logic [7:0] GDC_CMD_GET = 8'h08;
    localparam logic [7:0] GDC_CMD_LLO = 8'h11;
    localparam logic [7:0] GDC_CMD_DCL = 8'h14;
    localparam logic [7:0] GDC_CMD_SPE = 8'h18;
    localparam logic [7:0] GDC_CMD_SPD = 8'h19;
    localparam logic [7:0] GDC_CMD_UNL = 8'h3f;
    localparam logic [7:0] GDC_CMD_UNT = 8'h5f;
    localparam logic [7:0] GDC_LISTEN_BASE = 8'h20;
    localparam logic [7:0] GDC_TALK_BASE = 8'h40;

    // ****************************************
    // Byte fields
    // ****************************************
    localparam int GDC_GRP_HI = 6;
    localparam int GDC_GRP_LO = 5;
    localparam logic [1:0] GDC_GRP_CMD = 2'h0;
    localparam logic [1:0] GDC_GRP_LISTEN = 2'h1;
    localparam logic [1:0] GDC_GRP_TALK = 2'h2;
    localparam logic [1:0] GDC_GRP_SECOND = 2'h3;
    localparam int GDC_ADDR_W = 5;
    localparam logic [4:0] GDC_ADDR_MAX = 5'h1e;
    localparam logic [4:0] GDC_ADDR_RESET = 5'h00;
    localparam int GDC_STB_RQS_BIT = 6;
    localparam int GDC_CMD_BITS = 7;

    // ****************************************
    // Message buffer and timing
    // ****************************************
    localparam int GDC_FIFO_W = 9;
    localparam int GDC_FIFO_D = 4;
    localparam int GDC_CLK_NS = 25;
    localparam int GDC_SETTLE_NS = 50;
    localparam int GDC_SETTLE_CYC = (GDC_SETTLE_NS + GDC_CLK_NS - 1) / GDC_CLK_NS;
    localparam logic [3:0] GDC_SETTLE_CNT = 4'(GDC_SETTLE_CYC);

    typedef enum logic [1:0] {SH_IDLE, SH_SETTLE, SH_DAV, SH_HOLD} gdc_sh_type;
    typedef enum logic [1:0] {AH_OFF, AH_WAIT, AH_HOLD} gdc_ah_type;

endpackage

/* File: inc/gdc_bus_if.sv */
`timescale 1ns/10ps
`default_nettype none

// Open-collector bus in asserted sense: a line is true when any party enables
// its driver with a true output value.
interface gdc_bus_if;
    logic [7:0] dev_dio_o, ctl_dio_o;
    logic dev_dio_oe, ctl_dio_oe;
    logic dev_dav_o, dev_dav_oe, ctl_dav_o, ctl_dav_oe;
    logic dev_nrfd_o, dev_nrfd_oe, ctl_nrfd_o, ctl_nrfd_oe;
    logic dev_ndac_o, dev_ndac_oe, ctl_ndac_o, ctl_ndac_oe;
    logic dev_eoi_o, dev_eoi_oe, ctl_eoi_o, ctl_eoi_oe;
    logic dev_srq_o, dev_srq_oe;
    logic ctl_atn_o, ctl_atn_oe, ctl_ren_o, ctl_ren_oe, ctl_ifc_o, ctl_ifc_oe;
    logic [7:0] dio;
    logic dav, nrfd, ndac, eoi, srq, atn, ren, ifc;

    assign dio = ({8{dev_dio_oe}} & dev_dio_o) | ({8{ctl_dio_oe}} & ctl_dio_o);
    assign dav = (dev_dav_oe & dev_dav_o) | (ctl_dav_oe & ctl_dav_o);
    assign nrfd = (dev_nrfd_oe & dev_nrfd_o) | (ctl_nrfd_oe & ctl_nrfd_o);
    assign ndac = (dev_ndac_oe & dev_ndac_o) | (ctl_ndac_oe & ctl_ndac_o);
    assign eoi = (dev_eoi_oe & dev_eoi_o) | (ctl_eoi_oe & ctl_eoi_o);
    assign srq = dev_srq_oe & dev_srq_o;
    assign atn = ctl_atn_oe & ctl_atn_o;
    assign ren = ctl_ren_oe & ctl_ren_o;
    assign ifc = ctl_ifc_oe & ctl_ifc_o;

    modport dev (
        input dio, dav, nrfd, ndac, eoi, srq, atn, ren, ifc,
        output dev_dio_o, dev_dio_oe, dev_dav_o, dev_dav_oe, dev_nrfd_o, dev_nrfd_oe,
        output dev_ndac_o, dev_ndac_oe, dev_eoi_o, dev_eoi_oe, dev_srq_o, dev_srq_oe
    );
    modport ctl (
        input dio, dav, nrfd, ndac, eoi, srq, atn, ren, ifc,
        output ctl_dio_o, ctl_dio_oe, ctl_dav_o, ctl_dav_oe, ctl_nrfd_o, ctl_nrfd_oe,
        output ctl_ndac_o, ctl_ndac_oe, ctl_eoi_o, ctl_eoi_oe,
        output ctl_atn_o, ctl_atn_oe, ctl_ren_o, ctl_ren_oe, ctl_ifc_o, ctl_ifc_oe
    );
endinterface

`default_nettype wire

/* File: core/gdc_device.sv */
// Contract
// - Listen byte is primary address OR 0x20
// - Talk byte is primary address OR 0x40
// - Secondary command group bytes are ignored
// - Unlisten with attention ends listener state
// - Untalk with attention ends talker state
// - Address bytes decoded only under attention
// - Attention-false bytes go to message input
// - GTL, SDC, GET need listen addressing first
// - Decode LLO, DCL, SPE, SPD under attention
// - Controller: unlisten, listen address, command, release
// - Controller: address, drop attention, send text
// - Talk when addressed or when talk_only is set; own listen drops talk
// - Listen only when addressed; own talk drops listen
// - Full three-wire source and acceptor handshakes
// - Service request line and serial poll byte
// - Parallel poll commands are ignored
// - Never controller, no secondary addressing
// - Device clear resets the output stage and flushes messages; addressing stays
// - Group execute trigger starts a reading
// - Remote under remote enable; local on GTL
// - Selective clear acts like device clear
// - Primary address limited to 0..30
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Message buffer
// ****************************************
module gdc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push, pop;

    assign in_ready = (count_reg != FULL_CNT);
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ****************************************
// Instrument end
// ****************************************
module gdc_device
    import gdc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    gdc_bus_if.dev bus,
    input wire logic [4:0] prim_addr,
    input wire logic talk_only,
    output logic [7:0] msg_data,
    output logic msg_end,
    output logic msg_valid,
    input wire logic msg_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_end,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] status_byte,
    input wire logic svc_req,
    output logic listener,
    output logic talker,
    output logic remote,
    output logic lockout,
    output logic spoll_active,
    output logic rqs,
    output logic dev_clear,
    output logic trigger
);
    logic [14:0] sync1_reg, sync2_reg;
    logic [7:0] s_dio;
    logic s_dav, s_nrfd, s_ndac, s_eoi, s_atn, s_ren, s_ifc;
    logic [4:0] addr_reg;
    logic listener_reg, talker_reg, remote_reg, lockout_reg, spoll_reg, rqs_reg;
    logic clear_reg, trigger_reg, tx_ready_reg;
    gdc_ah_type ah_reg;
    gdc_sh_type sh_reg;
    logic [3:0] settle_reg;
    logic [8:0] out_reg;
    logic pend_reg, stb_reg;
    logic can_take, take, cmd_take, data_take, fifo_in_ready, fifo_valid;
    logic talk_act, take_tx, take_stb, sent;
    logic [6:0] cb;
    logic addr_hit;
    logic [8:0] fifo_out;

    // ****************************************
    // Bus input synchroniser
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {bus.dio, bus.dav, bus.nrfd, bus.ndac, bus.eoi, bus.atn, bus.ren, bus.ifc};
            sync2_reg <= sync1_reg;
        end
    end
    assign {s_dio, s_dav, s_nrfd, s_ndac, s_eoi, s_atn, s_ren, s_ifc} = sync2_reg;

    // Out-of-range settings are refused; the last good address stays
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            addr_reg <= GDC_ADDR_RESET;
        end else if (prim_addr <= GDC_ADDR_MAX) begin
            addr_reg <= prim_addr;
        end
    end

    // ****************************************
    // Acceptor handshake
    // ****************************************
    // Commands are always taken; data only while the buffer has room.
    assign can_take = s_atn | fifo_in_ready;
    assign take = (ah_reg == AH_WAIT) && s_dav && can_take;
    assign cmd_take = take & s_atn;
    assign data_take = take & ~s_atn;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ah_reg <= AH_OFF;
        end else begin
            case (ah_reg)
                // Our own dav may still sit in the synchroniser after attention aborts a talk
                AH_OFF: ah_reg <= ((s_atn | listener_reg) && !s_dav) ? AH_WAIT : AH_OFF;
                AH_WAIT: begin
                    if (take) begin
                        ah_reg <= AH_HOLD;
                    end else if (!(s_atn | listener_reg)) begin
                        ah_reg <= AH_OFF;
                    end
                end
                AH_HOLD: ah_reg <= s_dav ? AH_HOLD : AH_WAIT;
                default: ah_reg <= AH_OFF;
            endcase
        end
    end
    assign bus.dev_nrfd_o = 1'b1;
    assign bus.dev_nrfd_oe = (ah_reg == AH_HOLD) || ((ah_reg == AH_WAIT) && !can_take);
    assign bus.dev_ndac_o = 1'b1;
    assign bus.dev_ndac_oe = (ah_reg == AH_WAIT);

    // ****************************************
    // Command decode
    // ****************************************
    // Bit 7 is parity on some controllers; only seven bits are decoded.
    assign cb = s_dio[GDC_CMD_BITS-1:0];
    assign addr_hit = (cb[4:0] == addr_reg);

    always_ff @(posedge sys_clk) begin
        if (rst || s_ifc) begin
            listener_reg <= 1'b0;
            talker_reg <= 1'b0;
            spoll_reg <= 1'b0;
        end else if (cmd_take) begin
            if (cb == GDC_CMD_UNL[6:0]) begin
                listener_reg <= 1'b0;
            end else if (cb == GDC_CMD_UNT[6:0]) begin
                talker_reg <= 1'b0;
            end else if (cb[GDC_GRP_HI:GDC_GRP_LO] == GDC_GRP_LISTEN && addr_hit) begin
                listener_reg <= 1'b1;
                talker_reg <= 1'b0;
            end else if (cb[GDC_GRP_HI:GDC_GRP_LO] == GDC_GRP_TALK) begin
                talker_reg <= addr_hit;
                if (addr_hit) begin
                    listener_reg <= 1'b0;
                end
            end else if (cb == GDC_CMD_SPE[6:0]) begin
                spoll_reg <= 1'b1;
            end else if (cb == GDC_CMD_SPD[6:0]) begin
                spoll_reg <= 1'b0;
            end
            // Secondary group and parallel poll bytes fall through untouched
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || !s_ren) begin
            remote_reg <= 1'b0;
            lockout_reg <= 1'b0;
        end else if (cmd_take) begin
            if (cb[GDC_GRP_HI:GDC_GRP_LO] == GDC_GRP_LISTEN && addr_hit) begin
                remote_reg <= 1'b1;
            end else if (cb == GDC_CMD_GTL[6:0] && listener_reg) begin
                remote_reg <= 1'b0;
            end
            if (cb == GDC_CMD_LLO[6:0]) begin
                lockout_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clear_reg <= 1'b0;
            trigger_reg <= 1'b0;
        end else begin
            clear_reg <= cmd_take && (cb == GDC_CMD_DCL[6:0]
                || (cb == GDC_CMD_SDC[6:0] && listener_reg));
            trigger_reg <= cmd_take && cb == GDC_CMD_GET[6:0] && listener_reg;
        end
    end

    // ****************************************
    // Message input path
    // ****************************************
    gdc_fifo #(.WIDTH(GDC_FIFO_W), .DEPTH(GDC_FIFO_D)) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .flush(clear_reg),
        .in_valid(data_take),
        .in_ready(fifo_in_ready),
        .in_data({s_eoi, s_dio}),
        .out_valid(fifo_valid),
        .out_ready(msg_ready),
        .out_data(fifo_out)
    );
    assign {msg_end, msg_data} = fifo_out;
    assign msg_valid = fifo_valid;

    // ****************************************
    // Source handshake and serial poll
    // ****************************************
    assign talk_act = (talker_reg | talk_only) & ~s_atn;
    assign take_tx = tx_valid & tx_ready_reg;
    assign take_stb = ~pend_reg & ~take_tx & spoll_reg & talk_act & (sh_reg == SH_IDLE);
    assign sent = (sh_reg == SH_HOLD);

    always_ff @(posedge sys_clk) begin
        if (rst || clear_reg) begin
            pend_reg <= 1'b0;
            stb_reg <= 1'b0;
            out_reg <= '0;
            tx_ready_reg <= 1'b0;
        end else begin
            // One-byte holding stage: a byte survives attention and waits to be sent
            tx_ready_reg <= ~pend_reg & ~take_tx & ~take_stb & ~spoll_reg;
            if (take_tx) begin
                out_reg <= {tx_end, tx_data};
                pend_reg <= 1'b1;
                stb_reg <= 1'b0;
            end else if (take_stb) begin
                out_reg <= {1'b0, status_byte[7], rqs_reg, status_byte[5:0]};
                pend_reg <= 1'b1;
                stb_reg <= 1'b1;
            end else if (sent) begin
                pend_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sh_reg <= SH_IDLE;
            settle_reg <= '0;
        end else if (!talk_act || clear_reg) begin
            sh_reg <= SH_IDLE;
        end else begin
            case (sh_reg)
                SH_IDLE: begin
                    if (pend_reg) begin
                        sh_reg <= SH_SETTLE;
                        settle_reg <= GDC_SETTLE_CNT;
                    end
                end
                SH_SETTLE: begin
                    if (settle_reg != '0) begin
                        settle_reg <= settle_reg - 1'b1;
                    end else if (!s_nrfd) begin
                        sh_reg <= SH_DAV;
                    end
                end
                SH_DAV: sh_reg <= s_ndac ? SH_DAV : SH_HOLD;
                SH_HOLD: sh_reg <= SH_IDLE;
                default: sh_reg <= SH_IDLE;
            endcase
        end
    end
    assign bus.dev_dio_o = out_reg[7:0];
    assign bus.dev_dio_oe = (sh_reg != SH_IDLE) && (sh_reg != SH_HOLD);
    assign bus.dev_eoi_o = out_reg[8];
    assign bus.dev_eoi_oe = bus.dev_dio_oe;
    assign bus.dev_dav_o = 1'b1;
    assign bus.dev_dav_oe = (sh_reg == SH_DAV);

    // A new request wins over the clear that the finished poll byte brings
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rqs_reg <= 1'b0;
        end else if (svc_req) begin
            rqs_reg <= 1'b1;
        end else if (sent && stb_reg) begin
            rqs_reg <= 1'b0;
        end
    end
    assign bus.dev_srq_o = 1'b1;
    assign bus.dev_srq_oe = rqs_reg;

    assign listener = listener_reg;
    assign talker = talker_reg;
    assign remote = remote_reg;
    assign lockout = lockout_reg;
    assign spoll_active = spoll_reg;
    assign rqs = rqs_reg;
    assign dev_clear = clear_reg;
    assign trigger = trigger_reg;
    assign tx_ready = tx_ready_reg;
endmodule

`default_nettype wire

/* File: core/gdc_controller.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Bus controller end
// ****************************************
module gdc_controller
    import gdc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    gdc_bus_if.ctl bus,
    input wire logic atn_req,
    input wire logic ren_req,
    input wire logic ifc_req,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_end,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic lsn_en,
    output logic [7:0] rx_data,
    output logic rx_end,
    output logic rx_valid,
    output logic srq_seen
);
    logic [12:0] sync1_reg, sync2_reg;
    logic [7:0] s_dio;
    logic s_dav, s_nrfd, s_ndac, s_eoi, s_srq;
    logic atn_reg, ren_reg, ifc_reg, cmd_ready_reg, pend_reg;
    logic [8:0] out_reg;
    logic [3:0] settle_reg;
    gdc_sh_type sh_reg;
    gdc_ah_type ah_reg;
    logic [7:0] rx_data_reg;
    logic rx_end_reg, rx_valid_reg, srq_reg;
    logic take_cmd, lsn_act, take;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {bus.dio, bus.dav, bus.nrfd, bus.ndac, bus.eoi, bus.srq};
            sync2_reg <= sync1_reg;
        end
    end
    assign {s_dio, s_dav, s_nrfd, s_ndac, s_eoi, s_srq} = sync2_reg;

    // ****************************************
    // Management lines
    // ****************************************
    // Attention only moves between the controller's own bytes, so none of them straddles a change
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            atn_reg <= 1'b0;
            ren_reg <= 1'b0;
            ifc_reg <= 1'b0;
            srq_reg <= 1'b0;
        end else begin
            if (sh_reg == SH_IDLE && !pend_reg) begin
                atn_reg <= atn_req;
            end
            ren_reg <= ren_req;
            ifc_reg <= ifc_req;
            srq_reg <= s_srq;
        end
    end

    // ****************************************
    // Source handshake
    // ****************************************
    assign take_cmd = cmd_valid & cmd_ready_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmd_ready_reg <= 1'b0;
            pend_reg <= 1'b0;
            out_reg <= '0;
        end else begin
            cmd_ready_reg <= ~pend_reg & ~take_cmd & (atn_reg == atn_req);
            if (take_cmd) begin
                out_reg <= {cmd_end, cmd_data};
                pend_reg <= 1'b1;
            end else if (sh_reg == SH_HOLD) begin
                pend_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sh_reg <= SH_IDLE;
            settle_reg <= '0;
        end else begin
            case (sh_reg)
                SH_IDLE: begin
                    if (pend_reg) begin
                        sh_reg <= SH_SETTLE;
                        settle_reg <= GDC_SETTLE_CNT;
                    end
                end
                SH_SETTLE: begin
                    if (settle_reg != '0) begin
                        settle_reg <= settle_reg - 1'b1;
                    end else if (!s_nrfd) begin
                        sh_reg <= SH_DAV;
                    end
                end
                SH_DAV: sh_reg <= s_ndac ? SH_DAV : SH_HOLD;
                SH_HOLD: sh_reg <= SH_IDLE;
                default: sh_reg <= SH_IDLE;
            endcase
        end
    end

    // ****************************************
    // Acceptor handshake for talker data
    // ****************************************
    assign lsn_act = lsn_en & ~atn_reg;
    assign take = (ah_reg == AH_WAIT) && s_dav;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ah_reg <= AH_OFF;
        end else begin
            case (ah_reg)
                AH_OFF: ah_reg <= lsn_act ? AH_WAIT : AH_OFF;
                AH_WAIT: begin
                    if (take) begin
                        ah_reg <= AH_HOLD;
                    end else if (!lsn_act) begin
                        ah_reg <= AH_OFF;
                    end
                end
                AH_HOLD: ah_reg <= s_dav ? AH_HOLD : AH_WAIT;
                default: ah_reg <= AH_OFF;
            endcase
        end
    end

    // No back-pressure on the receive side: each byte is a one-cycle pulse
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_data_reg <= '0;
            rx_end_reg <= 1'b0;
            rx_valid_reg <= 1'b0;
        end else begin
            rx_valid_reg <= take;
            if (take) begin
                rx_data_reg <= s_dio;
                rx_end_reg <= s_eoi;
            end
        end
    end

    assign bus.ctl_dio_o = out_reg[7:0];
    assign bus.ctl_dio_oe = (sh_reg == SH_SETTLE) || (sh_reg == SH_DAV);
    assign bus.ctl_eoi_o = out_reg[8];
    assign bus.ctl_eoi_oe = bus.ctl_dio_oe & ~atn_reg;
    assign bus.ctl_dav_o = 1'b1;
    assign bus.ctl_dav_oe = (sh_reg == SH_DAV);
    assign bus.ctl_nrfd_o = 1'b1;
    assign bus.ctl_nrfd_oe = (ah_reg == AH_HOLD);
    assign bus.ctl_ndac_o = 1'b1;
    assign bus.ctl_ndac_oe = (ah_reg == AH_WAIT);
    assign bus.ctl_atn_o = 1'b1;
    assign bus.ctl_atn_oe = atn_reg;
    assign bus.ctl_ren_o = 1'b1;
    assign bus.ctl_ren_oe = ren_reg;
    assign bus.ctl_ifc_o = 1'b1;
    assign bus.ctl_ifc_oe = ifc_reg;
    assign cmd_ready = cmd_ready_reg;
    assign rx_data = rx_data_reg;
    assign rx_end = rx_end_reg;
    assign rx_valid = rx_valid_reg;
    assign srq_seen = srq_reg;
endmodule

`default_nettype wire

/* File: tb/gdc_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Handshake checks on the shared bus
// ****
module gdc_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] dio,
    input wire logic dav,
    input wire logic nrfd,
    input wire logic ndac,
    input wire logic atn,
    input wire logic dev_dio_oe,
    input wire logic ctl_dio_oe,
    input wire logic ctl_dav_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence src_go;
        $rose(dav);
    endsequence
    sequence acc_done;
        $fell(ndac) && dav;
    endsequence
    chk_dav_start: assert property (src_go |-> !nrfd && ndac)
        else $error("dav too soon");
    chk_dav_min: assert property (src_go |=> dav)
        else $error("dav short");
    chk_dav_hold: assert property (dav && ndac |=> dav)
        else $error("dav dropped");
    chk_dav_release: assert property (acc_done |-> ##[1:5] !dav)
        else $error("dav stuck");
    chk_dio_stable: assert property (dav && $past(dav) |-> $stable(dio))
        else $error("dio moved");
    chk_nrfd_hold: assert property (nrfd && dav |=> nrfd)
        else $error("nrfd dropped");
    // Attention may cut a talker short, but never the controller's own byte
    chk_atn_idle: assert property ($changed(atn) |-> !ctl_dav_oe)
        else $error("atn moved");
    chk_one_driver: assert property (!(dev_dio_oe && ctl_dio_oe))
        else $error("dio clash");
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic sys_clk = 0, rst = 1, atn_req = 0, ren_req = 1, cmd_valid = 0, msg_ready = 0;
    logic tx_valid = 0, svc_req = 0, lsn_en = 0, rx_valid, msg_valid, tx_ready, cmd_ready;
    logic listener, talker, remote, lockout, rqs, dev_clear, trigger;
    logic [7:0] cmd_data = 0, tx_data = 8'ha5, stb = 8'h81, rxb = 0, rx_data, msg_data;
    logic [4:0] paddr = 5'h07;
    int n_mismatch = 0, checks = 0, n_clr = 0, n_trg = 0;
    logic [7:0] q [5] = '{8'h2a, 8'h52, 8'h53, 8'h54, 8'h3f};
    gdc_bus_if bus ();
    gdc_device u_gdc_device (.sys_clk(sys_clk), .rst(rst), .bus(bus.dev), .prim_addr(paddr),
        .talk_only(1'b0), .msg_data(msg_data), .msg_end(), .msg_valid(msg_valid),
        .msg_ready(msg_ready), .tx_data(tx_data), .tx_end(1'b0), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .status_byte(stb), .svc_req(svc_req), .listener(listener),
        .talker(talker), .remote(remote), .lockout(lockout), .spoll_active(), .rqs(rqs),
        .dev_clear(dev_clear), .trigger(trigger));
    gdc_controller u_gdc_controller (.sys_clk(sys_clk), .rst(rst), .bus(bus.ctl),
        .atn_req(atn_req), .ren_req(ren_req), .ifc_req(1'b0), .cmd_data(cmd_data),
        .cmd_end(1'b0), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .lsn_en(lsn_en),
        .rx_data(rx_data), .rx_end(), .rx_valid(rx_valid), .srq_seen());
    gdc_monitor u_gdc_monitor (.sys_clk(sys_clk), .rst(rst), .dio(bus.dio), .dav(bus.dav),
        .nrfd(bus.nrfd), .ndac(bus.ndac), .atn(bus.atn), .dev_dio_oe(bus.dev_dio_oe),
        .ctl_dio_oe(bus.ctl_dio_oe), .ctl_dav_oe(bus.ctl_dav_oe));
    always #12.5 sys_clk = ~sys_clk;
    // Pulses are counted so a late check still sees them
    always @(posedge sys_clk) begin
        if (rx_valid === 1'b1) rxb <= rx_data;
        if (dev_clear === 1'b1) n_clr <= n_clr + 1;
        if (trigger === 1'b1) n_trg <= n_trg + 1;
    end
    task cmp(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Attention settles before the byte is offered, so the device sees the change before dav
    task snd(input logic a, input logic [7:0] d);
        if (a !== atn_req) begin
            atn_req <= a;
            repeat (4) @(posedge sys_clk);
        end
        cmd_data <= d;
        cmd_valid <= 1'b1;
        do @(posedge sys_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        repeat (40) @(posedge sys_clk);
    endtask
    task give_verdict;
        if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        give_verdict;
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        snd(1, 8'h3f);
        snd(1, 8'h27);
        cmp(listener, 1);
        cmp(remote, 1);
        snd(1, 8'h67);
        cmp({listener, talker}, 2'b10);
        snd(1, 8'h04);
        cmp(n_clr, 1);
        snd(1, 8'h08);
        cmp(n_trg, 1);
        snd(1, 8'h01);
        cmp(remote, 0);
        // Fifth byte waits on a full buffer until the drain below
        foreach (q[i]) snd(0, q[i]);
        cmp(listener, 1);
        msg_ready <= 1'b1;
        foreach (q[i]) begin
            do @(posedge sys_clk); while (msg_valid !== 1'b1);
            cmp(msg_data, q[i]);
        end
        snd(1, 8'h47);
        cmp({listener, talker}, 2'b01);
        snd(1, 8'h27);
        cmp({listener, talker}, 2'b10);
        snd(1, 8'h3f);
        cmp(listener, 0);
        snd(1, 8'h08);
        cmp(n_trg, 1);
        // Selective clear drops a held byte, so the reply is queued only after it
        tx_valid <= 1'b1;
        do @(posedge sys_clk); while (tx_ready !== 1'b1);
        tx_valid <= 1'b0;
        snd(1, 8'h47);
        lsn_en <= 1'b1;
        atn_req <= 1'b0;
        repeat (80) @(posedge sys_clk);
        cmp(rxb, 8'ha5);
        snd(1, 8'h5f);
        cmp(talker, 0);
        svc_req <= 1'b1;
        @(posedge sys_clk);
        svc_req <= 1'b0;
        repeat (10) @(posedge sys_clk);
        cmp({rqs, bus.srq}, 2'b11);
        snd(1, 8'h18);
        snd(1, 8'h47);
        atn_req <= 1'b0;
        // The poll byte repeats while addressed; only the first carries the request
        repeat (80) begin
            @(posedge sys_clk);
            if (rx_valid === 1'b1) break;
        end
        cmp(rx_data, 8'hc1);
        snd(1, 8'h19);
        snd(1, 8'h5f);
        cmp(rqs, 0);
        snd(1, 8'h11);
        cmp(lockout, 1);
        snd(1, 8'h14);
        cmp(n_clr, 2);
        give_verdict;
    end
endmodule
`default_nettype wire
